/* File: hw/rms_map.vh */
// Register map and constants of the remote management slave register block
//
// Overview of operation
// - Mask bit n enables analog channel n reporting
// - Four read-only protocol error flags, bits 0-3
// - Bit 4 selects intrusion or third fan status
// - Halt bit freezes the slave state machine
// - Abort bit returns state machine to idle
// - Bit 7 enables old style sensor, reset off
// - Remote controller address in bits 7:1
// - Sensor address in bits 7:1, bit0 reserved
// - Decode commands 00,01,02,03,23 with zero data
// - Read pointer readable, resets to zero
// - Write pointer readable, resets to zero
// - Override register forces the write pointer
// - Pointers index a 72-byte data buffer
`ifndef RMS_MAP_VH
`define RMS_MAP_VH
`define RMS_ADDR_W 8
`define RMS_OFF_MASK 8'h0c
`define RMS_OFF_MISC 8'h0d
`define RMS_OFF_RCADR 8'h0e
`define RMS_OFF_SNADR 8'h0f
`define RMS_OFF_RDPTR 8'h10
`define RMS_OFF_WRPTR 8'h11
`define RMS_OFF_PTRSET 8'h12
`define RMS_RST_BYTE 8'h00
`define RMS_BIT_PEC 0
`define RMS_BIT_COLL 1
`define RMS_BIT_UNEXP 2
`define RMS_BIT_NORS 3
`define RMS_BIT_SEL 4
`define RMS_BIT_HALT 5
`define RMS_BIT_ABORT 6
`define RMS_BIT_OLD 7
`define RMS_CMD_RESET 8'h00
`define RMS_CMD_PWRUP 8'h01
`define RMS_CMD_PWRDN 8'h02
`define RMS_CMD_PWRCYC 8'h03
`define RMS_CMD_POLL 8'h23
`define RMS_CMD_DATA 8'h00
`define RMS_BUF_DEPTH 8'd72
`endif

/* File: hw/rms_cmd_decode.v */
// Decoder of remote control command codes
`timescale 1ns/1ps
`include "rms_map.vh"
module rms_cmd_decode (
  input wire [7:0] cmd,
  input wire [7:0] data,
  output wire [4:0] hit
);
  wire data_ok;
  assign data_ok = (data == `RMS_CMD_DATA);
  assign hit[0] = data_ok && (cmd == `RMS_CMD_RESET);
  assign hit[1] = data_ok && (cmd == `RMS_CMD_PWRUP);
  assign hit[2] = data_ok && (cmd == `RMS_CMD_PWRDN);
  assign hit[3] = data_ok && (cmd == `RMS_CMD_PWRCYC);
  assign hit[4] = data_ok && (cmd == `RMS_CMD_POLL);
endmodule

/* File: hw/rms_regs.v */
// Control and status registers and buffer pointers of the remote management slave
`timescale 1ns/1ps
`include "rms_map.vh"
module rms_regs (
  input wire mclk,
  input wire rst,
  input wire [7:0] addr,
  input wire [7:0] wdata,
  input wire wr,
  input wire rd,
  output reg [7:0] rdata,
  input wire pec_err,
  input wire collision,
  input wire unexp_resp,
  input wire missing_restart,
  input wire third_fan_status,
  input wire intrusion_status,
  input wire [7:0] analog_status,
  input wire cmd_valid,
  input wire [7:0] cmd_code,
  input wire [7:0] cmd_data,
  input wire buf_rd_byte,
  input wire buf_wr_byte,
  output reg [7:0] analog_report,
  output reg selected_status,
  output wire old_style_sensor_enable,
  output wire [6:0] remote_controller_address,
  output wire [6:0] sensor_device_address,
  output reg [4:0] cmd_pulse,
  output wire sm_busy,
  output wire sm_halted
);
  localparam ST_IDLE = 3'b001;
  localparam ST_CMD = 3'b010;
  localparam ST_DATA = 3'b100;

  reg [7:0] mask_reg;
  reg [7:0] ctrl_reg;
  reg [3:0] err_reg;
  reg [6:0] rcadr_reg;
  reg [6:0] snadr_reg;
  reg [7:0] rdptr_reg;
  reg [7:0] wrptr_reg;
  reg [7:0] ptrset_reg;
  reg [2:0] state_reg;
  reg [2:0] state_next;
  reg [7:0] rd_mux;
  wire [4:0] hit;
  wire halt;
  wire abort;
  wire wr_hit;

  function [7:0] ptr_inc;
    input [7:0] p;
    begin
      if (p == `RMS_BUF_DEPTH - 8'd1) begin
        ptr_inc = 8'h00;
      end else begin
        ptr_inc = p + 8'd1;
      end
    end
  endfunction

  assign halt = ctrl_reg[`RMS_BIT_HALT];
  assign abort = ctrl_reg[`RMS_BIT_ABORT];
  assign old_style_sensor_enable = ctrl_reg[`RMS_BIT_OLD];
  assign remote_controller_address = rcadr_reg;
  assign sensor_device_address = snadr_reg;
  assign sm_busy = (state_reg != ST_IDLE);
  assign sm_halted = halt;
  assign wr_hit = wr && (addr == `RMS_OFF_PTRSET);

  rms_cmd_decode u_dec (
    .cmd(cmd_code),
    .data(cmd_data),
    .hit(hit)
  );

  // Commands take one cycle in ST_CMD then one pulse cycle in ST_DATA
  always @* begin
    case (state_reg)
      ST_IDLE: state_next = cmd_valid ? ST_CMD : ST_IDLE;
      ST_CMD: state_next = ST_DATA;
      ST_DATA: state_next = ST_IDLE;
      default: state_next = ST_IDLE;
    endcase
  end

  always @(posedge mclk) begin
    if (rst || abort) begin
      state_reg <= ST_IDLE;
      cmd_pulse <= 5'h00;
    end else if (halt) begin
      cmd_pulse <= 5'h00;
    end else begin
      state_reg <= state_next;
      cmd_pulse <= (state_reg == ST_CMD) ? hit : 5'h00;
    end
  end

  // Software writable registers; the low control nibble holds read-only flags
  always @(posedge mclk) begin
    if (rst) begin
      mask_reg <= `RMS_RST_BYTE;
      ctrl_reg <= `RMS_RST_BYTE;
      rcadr_reg <= 7'h00;
      snadr_reg <= 7'h00;
      ptrset_reg <= `RMS_RST_BYTE;
    end else if (wr) begin
      case (addr)
        `RMS_OFF_MASK: mask_reg <= wdata;
        `RMS_OFF_MISC: ctrl_reg <= {wdata[7:4], 4'h0};
        `RMS_OFF_RCADR: rcadr_reg <= wdata[7:1];
        `RMS_OFF_SNADR: snadr_reg <= wdata[7:1];
        `RMS_OFF_PTRSET: ptrset_reg <= wdata;
        default: ;
      endcase
    end
  end

  // Error flags follow the link engine's live status except while abort is set
  always @(posedge mclk) begin
    if (rst || abort) begin
      err_reg <= 4'h0;
    end else begin
      err_reg <= {missing_restart, unexp_resp, collision, pec_err};
    end
  end

  // Buffer pointers; a software override write wins over an advance
  always @(posedge mclk) begin
    if (rst) begin
      rdptr_reg <= `RMS_RST_BYTE;
      wrptr_reg <= `RMS_RST_BYTE;
    end else begin
      if (buf_rd_byte && !halt) begin
        rdptr_reg <= ptr_inc(rdptr_reg);
      end
      if (wr_hit) begin
        wrptr_reg <= wdata;
      end else if (buf_wr_byte && !halt) begin
        wrptr_reg <= ptr_inc(wrptr_reg);
      end
    end
  end

  always @(posedge mclk) begin
    if (rst) begin
      analog_report <= 8'h00;
      selected_status <= 1'b0;
    end else begin
      analog_report <= analog_status & mask_reg;
      selected_status <= ctrl_reg[`RMS_BIT_SEL] ? intrusion_status : third_fan_status;
    end
  end

  always @* begin
    case (addr)
      `RMS_OFF_MASK: rd_mux = mask_reg;
      `RMS_OFF_MISC: rd_mux = {ctrl_reg[7:4], err_reg};
      `RMS_OFF_RCADR: rd_mux = {rcadr_reg, 1'b0};
      `RMS_OFF_SNADR: rd_mux = {snadr_reg, 1'b0};
      `RMS_OFF_RDPTR: rd_mux = rdptr_reg;
      `RMS_OFF_WRPTR: rd_mux = wrptr_reg;
      `RMS_OFF_PTRSET: rd_mux = ptrset_reg;
      default: rd_mux = 8'h00;
    endcase
  end

  always @(posedge mclk) begin
    if (rst) begin
      rdata <= 8'h00;
    end else if (rd) begin
      rdata <= rd_mux;
    end else begin
      rdata <= 8'h00;
    end
  end
endmodule

/* File: verif/rms_chk_assertions.sv */
// Assertion checker of the register block
`timescale 1ns/1ps
module rms_chk (
  input wire mclk,
  input wire rst,
  input wire wr,
  input wire rd,
  input wire cmd_valid,
  input wire intrusion_status,
  input wire third_fan_status,
  input wire selected_status,
  input wire old_style_sensor_enable,
  input wire sm_busy,
  input wire sm_halted,
  input wire [7:0] addr,
  input wire [7:0] wdata,
  input wire [7:0] rdata,
  input wire [7:0] analog_status,
  input wire [7:0] analog_report,
  input wire [7:0] cmd_code,
  input wire [7:0] cmd_data,
  input wire [4:0] cmd_pulse
);
  reg [7:0] m;
  reg [7:0] c;
  always @(posedge mclk) m <= rst ? 8'h00 : (wr && addr == 8'h0c) ? wdata : m;
  always @(posedge mclk) c <= rst ? 8'h00 : (wr && addr == 8'h0d) ? wdata : c;
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  a_rdata_idle: assert property (!$past(rd) |-> rdata == 8'h00) else $error("rdata");
  a_mask_report: assert property (analog_report == ($past(analog_status) & $past(m))) else $error("mask");
  a_status_sel: assert property (
    selected_status == ($past(c[4]) ? $past(intrusion_status) : $past(third_fan_status))) else $error("sel");
  a_halt_freeze: assert property (sm_halted && $past(sm_halted) |-> $stable(sm_busy)) else $error("halt");
  a_abort_idle: assert property (c[6] |=> !sm_busy) else $error("abort");
  a_old_enable: assert property (old_style_sensor_enable == c[7]) else $error("old");
  a_rc_bit0: assert property (rd && addr == 8'h0e |=> !rdata[0]) else $error("bit0");
  a_pulse_one: assert property ($onehot0(cmd_pulse)) else $error("onehot");
  a_poll_cmd: assert property (
    cmd_valid && !sm_busy && !c[5] && !c[6] && cmd_code == 8'h23 && cmd_data == 8'h00
    |-> ##2 cmd_pulse == 5'h10) else $error("poll");
endmodule
bind rms_regs rms_chk u_rms_chk (.*);

/* File: verif/rms_link.sv */
// Remote controller model issuing commands
`timescale 1ns/1ps
module rms_link (
  input wire mclk,
  output reg cmd_valid = 1'b0,
  output reg [7:0] cmd_code = 8'h5a,
  output reg [7:0] cmd_data = 8'ha5
);
  task send(input [7:0] k, input [7:0] d);
    begin
      @(posedge mclk) {cmd_valid, cmd_code, cmd_data} <= {1'b1, k, d};
      @(posedge mclk) cmd_valid <= 1'b0;
      @(posedge mclk) {cmd_code, cmd_data} <= ~{k, d};
    end
  endtask
endmodule

/* File: verif/test_rms_regs.sv */
// Testbench of the register block
`timescale 1ns/1ps
module test_rms_regs;
  reg mclk = 0, rst = 1, wr = 0, rd = 0, buf_rd_byte = 0, buf_wr_byte = 0;
  reg third_fan_status = 0, intrusion_status = 1;
  reg [3:0] e = 4'h5;
  reg [7:0] addr = 8'h00, wdata = 8'h00, analog_status = 8'hff, i;
  wire pec_err = e[0], collision = e[1], unexp_resp = e[2], missing_restart = e[3];
  wire cmd_valid, selected_status, old_style_sensor_enable, sm_busy, sm_halted;
  wire [7:0] cmd_code, cmd_data, rdata, analog_report;
  wire [6:0] remote_controller_address, sensor_device_address;
  wire [4:0] cmd_pulse;
  integer n_fail = 0, tests_run = 0, cyc = 0;
  always #50 mclk = ~mclk;
  rms_regs u_rms_regs (.*);
  rms_link u_rms_link (.*);
  task chk(input [7:0] g, input [7:0] x);
    begin
      tests_run = tests_run + 1;
      if (g !== x) begin
        n_fail = n_fail + 1;
        $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, x);
      end
    end
  endtask
  task wrt(input [7:0] a, input [7:0] d);
    begin
      @(posedge mclk) {wr, addr, wdata} <= {1'b1, a, d};
      @(posedge mclk) wr <= 1'b0;
    end
  endtask
  task rdc(input [7:0] a, input [7:0] x);
    begin
      @(posedge mclk) {rd, addr} <= {1'b1, a};
      @(posedge mclk) rd <= 1'b0;
      #1 chk(rdata, x);
    end
  endtask
  task bump(input w);
    begin
      @(posedge mclk) {buf_wr_byte, buf_rd_byte} <= {w, !w};
      @(posedge mclk) {buf_wr_byte, buf_rd_byte} <= 2'b00;
    end
  endtask
  task cmd(input [7:0] k, input [7:0] d, input [4:0] x);
    begin
      u_rms_link.send(k, d);
      #1 chk({3'h0, cmd_pulse}, {3'h0, x});
      @(posedge mclk);
    end
  endtask
  task complete_run;
    begin
      $display("checks %0d mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
    end
  endtask
  always @(posedge mclk) begin
    cyc = cyc + 1;
    if (cyc == 2000) begin
      n_fail = n_fail + 1;
      complete_run;
    end
  end
  initial begin
    repeat (4) @(posedge mclk);
    rst <= 1'b0;
    for (i = 8'h0c; i < 8'h13; i = i + 1) rdc(i, (i == 8'h0d) ? 8'h05 : 8'h00);
    for (i = 0; i < 5; i = i + 1) cmd(i == 4 ? 8'h23 : i, 8'h00, 5'h01 << i);
    cmd(8'h01, 8'h01, 5'h00);
    wrt(8'h0c, 8'ha5);
    @(posedge mclk);
    #1 chk(analog_report, 8'ha5);
    wrt(8'h0d, 8'h9f);
    rdc(8'h0d, 8'h95);
    chk({6'h00, selected_status, old_style_sensor_enable}, 8'h03);
    wrt(8'h0e, 8'hff);
    rdc(8'h0e, 8'hfe);
    chk({1'b0, remote_controller_address}, 8'h7f);
    wrt(8'h0f, 8'h81);
    rdc(8'h0f, 8'h80);
    chk({1'b0, sensor_device_address}, 8'h40);
    repeat (3) bump(1);
    repeat (2) bump(0);
    rdc(8'h10, 8'h02);
    wrt(8'h11, 8'h33);
    rdc(8'h11, 8'h03);
    wrt(8'h12, 8'h46);
    repeat (2) bump(1);
    rdc(8'h11, 8'h00);
    rdc(8'h12, 8'h46);
    rdc(8'h20, 8'h00);
    // Halt lands while a command sits in its ST_CMD cycle
    fork
      u_rms_link.send(8'h02, 8'h00);
      wrt(8'h0d, 8'h20);
    join
    #1 chk({1'b0, sm_halted, sm_busy, cmd_pulse}, 8'h60);
    repeat (3) @(posedge mclk);
    #1 chk({1'b0, sm_halted, sm_busy, cmd_pulse}, 8'h60);
    wrt(8'h0d, 8'h00);
    repeat (2) @(posedge mclk);
    #1 chk({1'b0, sm_halted, sm_busy, cmd_pulse}, 8'h00);
    wrt(8'h0d, 8'h20);
    cmd(8'h01, 8'h00, 5'h00);
    wrt(8'h0d, 8'h40);
    rdc(8'h0d, 8'h40);
    cmd(8'h23, 8'h00, 5'h00);
    wrt(8'h0d, 8'h00);
    cmd(8'h23, 8'h00, 5'h10);
    e <= 4'ha;
    #1 chk({6'h00, selected_status, old_style_sensor_enable}, 8'h00);
    rdc(8'h0d, 8'h0a);
    complete_run;
  end
endmodule
